// ---- pkg/sdh_pkg.sv ----
// Purpose : shared types and constants for the signed divide / halving lane datapath
// Assumes : one core clock, operands already read from the register file
// Notes   : all results leave the datapath one clock after the request
package sdh_pkg;

  // ==========================================================================
  // widths and special register numbers
  // ==========================================================================
  localparam int unsigned        DATA_W   = 32;
  localparam logic [3:0]         REG_SP   = 4'hd;  // register 13
  localparam logic [3:0]         REG_PC   = 4'hf;  // register 15
  localparam logic [31:0]        ZERO_RES = 32'h0000_0000;
  localparam logic [31:0]        MOST_NEG = 32'h8000_0000;
  localparam logic [31:0]        MINUS1   = 32'hffff_ffff;

  // ==========================================================================
  // operation codes
  // ==========================================================================
  typedef enum logic [2:0] {
    SDH_NOP    = 3'b000,
    SDH_QUOT   = 3'b001,  // signed_quotient_op
    SDH_SEL    = 3'b010,  // byte select by lane_compare_flags
    SDH_EVT    = 3'b011,  // event_broadcast_hint
    SDH_HADD16 = 3'b100,  // halving_add_halfword_lanes
    SDH_HADD8  = 3'b101,  // halving_add_byte_lanes
    SDH_HDSX   = 3'b110,  // halving_diff_sum_exchanged
    SDH_HSDX   = 3'b111   // halving_sum_diff_exchanged
  } sdh_op_t;

  // ==========================================================================
  // request from the issue stage and result to write-back
  // ==========================================================================
  typedef struct packed {
    logic              valid;      // one-cycle issue strobe
    sdh_op_t           op;
    logic              cond_pass;  // condition check outcome
    logic              trap_en;    // integer zero-divide trapping enabled
    logic [3:0]        rd;
    logic [3:0]        rn;
    logic [3:0]        rm;
    logic [31:0]       opa;        // value of first operand register
    logic [31:0]       opb;        // value of second operand register
    logic [3:0]        lane_flags; // lane_compare_flags
  } sdh_req_t;

  typedef struct packed {
    logic              wr_en;      // destination write strobe
    logic [3:0]        rd;
    logic [31:0]       data;
    logic              div_trap;   // usage_error_trap request, zero divide
    logic              event_out;  // event broadcast to all processors
    logic              unpred;     // unpredictable register choice seen
  } sdh_res_t;

  localparam sdh_res_t RES_RST = '0;

endpackage

// ---- rtl/sdh_alu.sv ----
// Purpose : execute signed divide, byte select, event hint and signed halving lane ops
// Assumes : request fields are stable and synchronous to clk; one request per cycle
// Notes   : single-cycle datapath, all results registered; flags are never written
//
// Functional notes
// - zero divisor raises zero-divide trap if enabled, else writes zero.
// - nonzero divisor gives signed quotient rounded toward zero, low 32 bits.
// - most negative divided by minus one yields most negative, no overflow sign.
// - byte select takes lane from first operand when its compare flag is one.
// - byte select and byte halving add with register 13 or 15 are unpredictable.
// - event hint with passing condition signals event to every processor.
// - event hint behaves as no-operation apart from the event.
// - nothing is written or signalled when the condition check fails.
// - halfword halving add writes bits 16:1 of each signed 17-bit sum.
// - byte halving add writes bits 8:1 of each signed 9-bit sum.
// - diff-sum exchanged: low = (a.lo - b.hi)/2, high = (a.hi + b.lo)/2.
// - sum-diff exchanged swaps second operand halves, one add and one subtract halved.
// - sum-diff exchanged: low = (a.lo + b.hi)/2, high = (a.hi - b.lo)/2.
`timescale 1ns/1ps
module sdh_alu (
  input  wire logic             clk,
  input  wire logic             nrst,
  input  wire sdh_pkg::sdh_req_t req,
  output      sdh_pkg::sdh_res_t res
);

  // ==========================================================================
  // lane helpers
  // ==========================================================================
  // halved signed halfword sum or difference, widened by one bit first
  function automatic logic [15:0] half16(input logic [15:0] x,
                                          input logic [15:0] y,
                                          input logic        sub);
    logic [16:0] s;
    s = sub ? ({x[15], x} - {y[15], y}) : ({x[15], x} + {y[15], y});
    return s[16:1];
  endfunction

  // halved signed byte sum, widened by one bit first
  function automatic logic [7:0] half8(input logic [7:0] x, input logic [7:0] y);
    logic [8:0] s;
    s = {x[7], x} + {y[7], y};
    return s[8:1];
  endfunction

  // register 13 or 15 selected
  function automatic logic bad_reg(input logic [3:0] r);
    return (r == sdh_pkg::REG_SP) || (r == sdh_pkg::REG_PC);
  endfunction

  // byte mask with ff in every lane whose compare flag is set
  function automatic logic [31:0] lane_mask(input logic [3:0] f);
    logic [31:0] m;
    for (int i = 0; i < 4; i++) begin
      m[i*8 +: 8] = {8{f[i]}};
    end
    return m;
  endfunction

  // ==========================================================================
  // divider
  // ==========================================================================
  logic               div_zero;
  logic [31:0]        div_den;
  logic signed [32:0] quot33;

  // 33-bit signed divide so that most negative over minus one gives +2^31
  always_comb begin
    div_zero = (req.opb == sdh_pkg::ZERO_RES);
    div_den  = div_zero ? 32'h0000_0001 : req.opb;  // keeps the unused divide defined
    quot33   = $signed({req.opa[31], req.opa}) / $signed({div_den[31], div_den});
  end

  // ==========================================================================
  // next state
  // ==========================================================================
  sdh_pkg::sdh_res_t res_q;
  sdh_pkg::sdh_res_t res_d;
  logic              go;
  logic              unp;

  always_comb begin
    res_d    = sdh_pkg::RES_RST;
    res_d.rd = req.rd;
    go       = req.valid && req.cond_pass;
    unp      = bad_reg(req.rd) || bad_reg(req.rn) || bad_reg(req.rm);
    if (go) begin
      case (req.op)
        sdh_pkg::SDH_QUOT: begin
          // no flag output exists, so divide cannot touch flags
          if (div_zero) begin
            res_d.div_trap = req.trap_en;
            res_d.wr_en    = !req.trap_en;
            res_d.data     = sdh_pkg::ZERO_RES;
          end else begin
            res_d.wr_en = 1'b1;
            res_d.data  = quot33[31:0];
          end
        end
        sdh_pkg::SDH_SEL: begin
          res_d.unpred = unp;
          res_d.wr_en  = !unp;
          for (int i = 0; i < 4; i++) begin
            res_d.data[i*8 +: 8] = req.lane_flags[i] ? req.opa[i*8 +: 8]
                                                     : req.opb[i*8 +: 8];
          end
        end
        sdh_pkg::SDH_EVT: begin
          res_d.event_out = 1'b1;
        end
        sdh_pkg::SDH_HADD16: begin
          res_d.wr_en        = 1'b1;
          res_d.data[15:0]   = half16(req.opa[15:0], req.opb[15:0], 1'b0);
          res_d.data[31:16]  = half16(req.opa[31:16], req.opb[31:16], 1'b0);
        end
        sdh_pkg::SDH_HADD8: begin
          res_d.unpred = unp;
          res_d.wr_en  = !unp;
          for (int i = 0; i < 4; i++) begin
            res_d.data[i*8 +: 8] = half8(req.opa[i*8 +: 8], req.opb[i*8 +: 8]);
          end
        end
        sdh_pkg::SDH_HDSX: begin
          res_d.wr_en        = 1'b1;
          res_d.data[15:0]   = half16(req.opa[15:0], req.opb[31:16], 1'b1);
          res_d.data[31:16]  = half16(req.opa[31:16], req.opb[15:0], 1'b0);
        end
        sdh_pkg::SDH_HSDX: begin
          res_d.wr_en        = 1'b1;
          res_d.data[15:0]   = half16(req.opa[15:0], req.opb[31:16], 1'b0);
          res_d.data[31:16]  = half16(req.opa[31:16], req.opb[15:0], 1'b1);
        end
        default: begin
          res_d.wr_en = 1'b0;
        end
      endcase
    end
    // a refused or silent request leaves the data word clean
    if (!res_d.wr_en) begin
      res_d.data = sdh_pkg::ZERO_RES;
    end
  end

  // ==========================================================================
  // state register
  // ==========================================================================
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      res_q <= sdh_pkg::RES_RST;
    end else begin
      res_q <= res_d;
    end
  end

  assign res = res_q;

  // ==========================================================================
  // checks
  // ==========================================================================
  sequence s_quot_issue;
    req.valid && req.cond_pass && (req.op == sdh_pkg::SDH_QUOT);
  endsequence

  sequence s_evt_issue;
    req.valid && req.cond_pass && (req.op == sdh_pkg::SDH_EVT);
  endsequence

  sequence s_sel_issue;
    req.valid && req.cond_pass && (req.op == sdh_pkg::SDH_SEL);
  endsequence

  sequence s_hadd16_issue;
    req.valid && req.cond_pass && (req.op == sdh_pkg::SDH_HADD16);
  endsequence

  sequence s_hadd8_issue;
    req.valid && req.cond_pass && (req.op == sdh_pkg::SDH_HADD8);
  endsequence

  sequence s_hdsx_issue;
    req.valid && req.cond_pass && (req.op == sdh_pkg::SDH_HDSX);
  endsequence

  sequence s_hsdx_issue;
    req.valid && req.cond_pass && (req.op == sdh_pkg::SDH_HSDX);
  endsequence

  // event pulse with no write or trap beside it
  sequence s_evt_answer;
    res.event_out && !res.wr_en && !res.div_trap;
  endsequence

  zero_div_trap_a: assert property (@(posedge clk) disable iff (!nrst)
    s_quot_issue and (req.opb == sdh_pkg::ZERO_RES) |=>
      (res.div_trap == $past(req.trap_en)) && (res.wr_en != $past(req.trap_en))
      && (res.data == sdh_pkg::ZERO_RES))
    else $error("zero divisor handled wrongly");

  quot_value_a: assert property (@(posedge clk) disable iff (!nrst)
    s_quot_issue and (req.opb != sdh_pkg::ZERO_RES) and !req.opa[31] and !req.opb[31] |=>
      res.wr_en && (res.data == ($past(req.opa) / $past(req.opb))))
    else $error("quotient wrong");

  quot_ovf_a: assert property (@(posedge clk) disable iff (!nrst)
    s_quot_issue and (req.opa == sdh_pkg::MOST_NEG) and (req.opb == sdh_pkg::MINUS1) |=>
      res.wr_en && (res.data == sdh_pkg::MOST_NEG) && !res.div_trap)
    else $error("most negative over minus one wrong");

  sel_lane_a: assert property (@(posedge clk) disable iff (!nrst)
    req.valid && req.cond_pass && (req.op == sdh_pkg::SDH_SEL) && !unp |=>
      res.data[31:24] == ($past(req.lane_flags[3]) ? $past(req.opa[31:24])
                                                   : $past(req.opb[31:24])))
    else $error("byte select lane wrong");

  unpred_reg_a: assert property (@(posedge clk) disable iff (!nrst)
    req.valid && req.cond_pass && (req.op == sdh_pkg::SDH_HADD8) && (req.rm == sdh_pkg::REG_PC)
      |=> res.unpred && !res.wr_en)
    else $error("register 15 not flagged");

  event_hint_a: assert property (@(posedge clk) disable iff (!nrst)
    s_evt_issue |=> s_evt_answer)
    else $error("event hint not broadcast");

  cond_fail_a: assert property (@(posedge clk) disable iff (!nrst)
    !(req.valid && req.cond_pass) |=> !res.wr_en && !res.event_out && !res.div_trap)
    else $error("effect without passing condition");

  hadd16_lane_a: assert property (@(posedge clk) disable iff (!nrst)
    req.valid && req.cond_pass && (req.op == sdh_pkg::SDH_HADD16) |=>
      res.wr_en && ($signed(res.data[31:16]) ==
        (($signed({$past(req.opa[31]), $past(req.opa[31:16])})
          + $signed({$past(req.opb[31]), $past(req.opb[31:16])})) >>> 1)))
    else $error("halfword halving add wrong");

  hsdx_lane_a: assert property (@(posedge clk) disable iff (!nrst)
    req.valid && req.cond_pass && (req.op == sdh_pkg::SDH_HSDX) |=>
      $signed(res.data[15:0]) ==
        (($signed({$past(req.opa[15]), $past(req.opa[15:0])})
          + $signed({$past(req.opb[31]), $past(req.opb[31:16])})) >>> 1))
    else $error("exchanged sum lane wrong");

  // pulse only after a passing hint, and no register touched by it
  evt_single_a: assert property (@(posedge clk) disable iff (!nrst)
    res.event_out |-> $past(req.valid && req.cond_pass && (req.op == sdh_pkg::SDH_EVT)))
    else $error("event without a passing hint");

  evt_no_write_a: assert property (@(posedge clk) disable iff (!nrst)
    s_evt_issue |=> !res.unpred && (res.data == sdh_pkg::ZERO_RES))
    else $error("event hint changed a register");

  // full signed quotient, overflow pair left to its own check
  quot_signed_a: assert property (@(posedge clk) disable iff (!nrst)
    s_quot_issue and (req.opb != sdh_pkg::ZERO_RES)
      and !((req.opa == sdh_pkg::MOST_NEG) && (req.opb == sdh_pkg::MINUS1)) |=>
      res.wr_en && ($signed(res.data) == ($signed($past(req.opa)) / $signed($past(req.opb)))))
    else $error("signed quotient wrong");

  quot_side_a: assert property (@(posedge clk) disable iff (!nrst)
    s_quot_issue |=> !res.event_out && !res.unpred)
    else $error("divide raised a side output");

  sel_lanes_a: assert property (@(posedge clk) disable iff (!nrst)
    s_sel_issue and !unp |=> res.wr_en && (res.data ==
      (($past(req.opa) & lane_mask($past(req.lane_flags)))
      | ($past(req.opb) & ~lane_mask($past(req.lane_flags))))))
    else $error("byte select word wrong");

  sel_unpred_a: assert property (@(posedge clk) disable iff (!nrst)
    s_sel_issue and (req.rd == sdh_pkg::REG_SP) |=> res.unpred && !res.wr_en)
    else $error("register 13 not flagged");

  // halving lanes, each sum widened by one sign bit before the shift
  hadd16_low_a: assert property (@(posedge clk) disable iff (!nrst)
    s_hadd16_issue |=> ($signed(res.data[15:0]) ==
      (($signed({$past(req.opa[15]), $past(req.opa[15:0])})
        + $signed({$past(req.opb[15]), $past(req.opb[15:0])})) >>> 1)))
    else $error("low halfword halving add wrong");

  hadd8_lane_a: assert property (@(posedge clk) disable iff (!nrst)
    s_hadd8_issue and !unp |=> res.wr_en && ($signed(res.data[31:24]) ==
      (($signed({$past(req.opa[31]), $past(req.opa[31:24])})
        + $signed({$past(req.opb[31]), $past(req.opb[31:24])})) >>> 1)))
    else $error("top byte halving add wrong");

  hdsx_low_a: assert property (@(posedge clk) disable iff (!nrst)
    s_hdsx_issue |=> res.wr_en && ($signed(res.data[15:0]) ==
      (($signed({$past(req.opa[15]), $past(req.opa[15:0])})
        - $signed({$past(req.opb[31]), $past(req.opb[31:16])})) >>> 1)))
    else $error("exchanged difference lane wrong");

  hdsx_high_a: assert property (@(posedge clk) disable iff (!nrst)
    s_hdsx_issue |=> ($signed(res.data[31:16]) ==
      (($signed({$past(req.opa[31]), $past(req.opa[31:16])})
        + $signed({$past(req.opb[15]), $past(req.opb[15:0])})) >>> 1)))
    else $error("exchanged sum high lane wrong");

  hsdx_high_a: assert property (@(posedge clk) disable iff (!nrst)
    s_hsdx_issue |=> res.wr_en && ($signed(res.data[31:16]) ==
      (($signed({$past(req.opa[31]), $past(req.opa[31:16])})
        - $signed({$past(req.opb[15]), $past(req.opb[15:0])})) >>> 1)))
    else $error("exchanged difference high lane wrong");

  // sign of a like-signed halfword sum survives the halving
  no_wrap_pos_a: assert property (@(posedge clk) disable iff (!nrst)
    s_hadd16_issue and !req.opa[31] and !req.opb[31] |=> !res.data[31])
    else $error("positive halfword sum wrapped");

  no_wrap_neg_a: assert property (@(posedge clk) disable iff (!nrst)
    s_hadd16_issue and req.opa[31] and req.opb[31] |=> res.data[31])
    else $error("negative halfword sum wrapped");

  idle_data_a: assert property (@(posedge clk) disable iff (!nrst)
    !res.wr_en |-> (res.data == sdh_pkg::ZERO_RES))
    else $error("data not clean without a write");

endmodule

// ---- tb/sdh_core_mdl.sv ----
// Purpose : write-back side of the core, a register file fed by the datapath
// Assumes : at most one write per cycle
// Notes   : behavioural; counts event broadcasts for the bench
`timescale 1ns/1ps
module sdh_core_mdl (
  input wire logic              clk,
  input wire logic              nrst,
  input wire sdh_pkg::sdh_res_t res
);
  // ==========================================================================
  // register file
  // ==========================================================================
  logic [31:0] regs_q [16];
  int          events_q;

  // store each write, count each broadcast
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      events_q <= 0;
    end else begin
      if (res.wr_en) regs_q[res.rd] <= res.data;
      if (res.event_out) events_q <= events_q + 1;
    end
  end
endmodule

// ---- tb/testbench.sv ----
// Purpose : self-checking bench for the divide / select / halving datapath
// Assumes : one-cycle answer after the issue edge
// Notes   : every scenario waits a fixed cycle, a watchdog cuts a hang
`timescale 1ns/1ps
module testbench;
  logic              clk = 1'b0;
  logic              nrst = 1'b0;
  sdh_pkg::sdh_req_t req = '0;
  sdh_pkg::sdh_res_t res;
  sdh_pkg::sdh_res_t got;
  int                mismatches = 0;
  int                comparisons = 0;

  // ==========================================================================
  // clock, design and core model
  // ==========================================================================
  always #20 clk = ~clk;
  sdh_alu uut (.clk(clk), .nrst(nrst), .req(req), .res(res));
  sdh_core_mdl core (.clk(clk), .nrst(nrst), .res(res));

  // ==========================================================================
  // compare, issue and reference helpers
  // ==========================================================================
  task automatic chk32(input string what, input logic [31:0] exp, input logic [31:0] seen);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic chk1(input string what, input logic exp, input logic seen);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %b seen %b", what, exp, seen);
    end
  endtask
  // one-cycle strobe, result read once the answer edge has landed
  task automatic issue(input sdh_pkg::sdh_op_t op, input logic cp, input logic te,
                       input logic [11:0] r, input logic [31:0] a, input logic [31:0] b,
                       input logic [3:0] fl);
    @(posedge clk);
    req <= '{1'b1, op, cp, te, r[11:8], r[7:4], r[3:0], a, b, fl};
    @(posedge clk);
    req.valid <= 1'b0;
    #1 got = res;
  endtask
  // halved signed sum or difference with one guard bit
  function automatic logic [15:0] h16(input logic [15:0] x, input logic [15:0] y, input logic s);
    logic [16:0] r;
    r = s ? {x[15], x} - {y[15], y} : {x[15], x} + {y[15], y};
    return r[16:1];
  endfunction
  function automatic logic [7:0] h8(input logic [7:0] x, input logic [7:0] y);
    logic [15:0] r;
    r = h16({{8{x[7]}}, x}, {{8{y[7]}}, y}, 1'b0);
    return r[7:0];
  endfunction

  // ==========================================================================
  // scenarios
  // ==========================================================================
  task automatic t_quot();
    logic [31:0] tv [4][3];
    tv = '{'{32'h7, 32'hffff_fffe, 32'hffff_fffd}, '{32'hffff_fff9, 32'h2, 32'hffff_fffd},
           '{sdh_pkg::MOST_NEG, sdh_pkg::MINUS1, sdh_pkg::MOST_NEG}, '{32'h64, 32'h7, 32'he}};
    foreach (tv[i]) begin
      issue(sdh_pkg::SDH_QUOT, 1'b1, 1'b1, 12'h123, tv[i][0], tv[i][1], 4'h0);
      chk32("quotient", tv[i][2], got.data);
      chk1("quotient trap", 1'b0, got.div_trap);
      chk32("quotient dest", 32'h1, {28'h0, got.rd});
    end
    issue(sdh_pkg::SDH_QUOT, 1'b1, 1'b0, 12'h456, 32'h55, 32'h0, 4'h0);
    chk1("zero div write", 1'b1, got.wr_en);
    chk32("zero div data", sdh_pkg::ZERO_RES, got.data);
    issue(sdh_pkg::SDH_QUOT, 1'b1, 1'b1, 12'h456, 32'h55, 32'h0, 4'h0);
    chk1("zero div trap", 1'b1, got.div_trap);
    chk1("trap write", 1'b0, got.wr_en);
    chk32("write back", 32'he, core.regs_q[1]);
    chk32("zero write back", sdh_pkg::ZERO_RES, core.regs_q[4]);
  endtask
  task automatic t_sel();
    logic [31:0] e;
    for (int f = 0; f < 16; f++) begin
      for (int l = 0; l < 4; l++) e[8*l+:8] = f[l] ? 8'(8'h11 * (l + 1)) : 8'haa + 8'(l);
      issue(sdh_pkg::SDH_SEL, 1'b1, 1'b0, 12'h234, 32'h44332211, 32'hadacabaa, 4'(f));
      chk32("byte select", e, got.data);
    end
    issue(sdh_pkg::SDH_SEL, 1'b1, 1'b0, 12'hd12, 32'h1, 32'h2, 4'h0);
    chk1("select sp unpred", 1'b1, got.unpred);
    issue(sdh_pkg::SDH_HADD8, 1'b1, 1'b0, 12'h21f, 32'h1, 32'h2, 4'h0);
    chk1("hadd8 pc unpred", 1'b1, got.unpred);
    chk1("hadd8 pc write", 1'b0, got.wr_en);
  endtask
  task automatic t_event();
    issue(sdh_pkg::SDH_EVT, 1'b1, 1'b0, 12'h0, 32'h0, 32'h0, 4'h0);
    chk1("event out", 1'b1, got.event_out);
    chk1("event write", 1'b0, got.wr_en);
    issue(sdh_pkg::SDH_NOP, 1'b1, 1'b1, 12'h123, 32'h1, 32'h0, 4'hf);
    chk1("nop effect", 1'b0, got.wr_en | got.event_out | got.div_trap);
    for (int k = 1; k < 8; k++) begin
      issue(sdh_pkg::sdh_op_t'(k), 1'b0, 1'b1, 12'h123, 32'h7fff8001, 32'h0, 4'hf);
      chk1("cond fail write", 1'b0, got.wr_en);
      chk1("cond fail side", 1'b0, got.event_out | got.div_trap);
    end
    chk32("event count", 32'h1, 32'(core.events_q));
  endtask
  task automatic t_halve();
    logic [31:0] a [3] = '{32'h7fff8000, 32'h80017fff, 32'h12345678};
    logic [31:0] b [3] = '{32'h7fff8000, 32'h80008000, 32'hfedcba98};
    foreach (a[i]) begin
      issue(sdh_pkg::SDH_HADD16, 1'b1, 1'b0, 12'h123, a[i], b[i], 4'h0);
      chk32("hadd16", {h16(a[i][31:16], b[i][31:16], 0), h16(a[i][15:0], b[i][15:0], 0)},
            got.data);
      issue(sdh_pkg::SDH_HADD8, 1'b1, 1'b0, 12'h123, a[i], b[i], 4'h0);
      chk32("hadd8", {h8(a[i][31:24], b[i][31:24]), h8(a[i][23:16], b[i][23:16]),
            h8(a[i][15:8], b[i][15:8]), h8(a[i][7:0], b[i][7:0])}, got.data);
      issue(sdh_pkg::SDH_HDSX, 1'b1, 1'b0, 12'h123, a[i], b[i], 4'h0);
      chk32("diff sum x", {h16(a[i][31:16], b[i][15:0], 0), h16(a[i][15:0], b[i][31:16], 1)},
            got.data);
      issue(sdh_pkg::SDH_HSDX, 1'b1, 1'b0, 12'h123, a[i], b[i], 4'h0);
      chk32("sum diff x", {h16(a[i][31:16], b[i][15:0], 1), h16(a[i][15:0], b[i][31:16], 0)},
            got.data);
    end
    issue(sdh_pkg::SDH_HADD16, 1'b1, 1'b0, 12'h123, a[2], b[2], 4'h0);
    chk32("hadd16 known", 32'h0888_0888, got.data);
    issue(sdh_pkg::SDH_HDSX, 1'b1, 1'b0, 12'h123, a[1], b[1], 4'h0);
    chk32("diff sum x known", 32'h8000_7fff, got.data);
    issue(sdh_pkg::SDH_HSDX, 1'b1, 1'b0, 12'h123, a[1], b[1], 4'h0);
    chk32("sum diff x known", 32'h0000_ffff, got.data);
  endtask

  // ==========================================================================
  // verdict, watchdog and main sequence
  // ==========================================================================
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  initial begin
    #400000;
    mismatches++;
    conclude();
  end
  initial begin
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    t_quot();
    t_sel();
    t_event();
    t_halve();
    conclude();
  end
endmodule
